// ---- logic/stp_pkg.sv ----
// shared constants and types for the stimulus trace packetizer
package stp_pkg;
  localparam int STP_ADDR_W = 12;
  localparam int STP_PORT_LSB = 8;
  localparam int STP_PORT_W = 4;
  localparam int STP_MASTER_W = 8;
  localparam int STP_BIT_INVAR = 7;
  localparam int STP_BIT_NODATA = 6;
  localparam int STP_BIT_SUB = 5;
  localparam int STP_BIT_NOMARK = 4;
  localparam int STP_BIT_TRIG = 4;
  localparam int STP_BIT_NOSTAMP = 3;
  localparam int STP_FIFO_DEPTH = 4;
  localparam int STP_LEVEL_W = 3;
  localparam logic [STP_LEVEL_W-1:0] STP_STAMP_ROOM = 3'h2;
  // feature word: bits [3:0] fundamental size code, 1 means 32 bit
  localparam logic [31:0] STP_FEAT_RESET = 32'h0000_0001;
  // version word, arbitrary value
  localparam logic [31:0] STP_VERSION_WORD = 32'h0000_0002;
  // stamp counter rate in hertz, equal to the 125 MHz clock
  localparam logic [31:0] STP_FREQ_HZ = 32'h0773_5940;
  localparam logic [31:0] STP_TIME_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} stp_size_t;

  typedef enum logic [3:0] {
    PK_PLAIN, PK_STAMPED_WORD, PK_MARKED_WORD, PK_MARKED_STAMPED_WORD,
    PK_FLAG, PK_MARKER_STAMPED, PK_TRIGGER, PK_EVENT_STAMPED,
    PK_LOST, PK_ASYNC, PK_VERSION, PK_FREQ
  } stp_kind_t;

  typedef struct packed {
    logic [STP_ADDR_W-1:0] addr;
    stp_size_t size;
    logic [31:0] data;
    logic [STP_MASTER_W-1:0] master;
    logic more;
  } stp_write_t;

  typedef struct packed {
    stp_kind_t kind;
    logic [STP_MASTER_W-1:0] master;
    logic [STP_PORT_W-1:0] channel;
    stp_size_t size;
    logic [31:0] data;
    logic [31:0] stamp;
  } stp_packet_t;
endpackage

// ---- logic/stp_fifo.sv ----
// packet queue with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [CW-1:0] level_r;
  logic push;
  logic pop;

  // handshakes; depth is a power of two so pointers wrap by overflow
  assign inReady = (level_r != CW'(DEPTH));
  assign outValid = (level_r != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_r];
  assign level = level_r;

  // storage
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  // pointers and fill level
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + PW'(push);
      rdPtr_r <= rdPtr_r + PW'(pop);
      level_r <= level_r + CW'(push) - CW'(pop);
    end
  end
endmodule // stp_fifo
`default_nettype wire

// ---- logic/stimulus_trace_packetizer.sv ----
// stimulus port writes turned into trace packets through a small queue
`timescale 1ns/1ps
`default_nettype none
module stimulus_trace_packetizer
  import stp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wrValid,
  output logic wrReady,
  input wire stp_write_t wrReq,
  input wire logic bigEndianSys,
  input wire logic stampEnable,
  input wire logic syncReq,
  output logic pktValid,
  input wire logic pktReady,
  output stp_packet_t pkt,
  output logic traceLost,
  output logic [31:0] featureRegisterOne
);
  // sync sequence: async, version, then freq only while stamps are enabled
  typedef enum logic [1:0] {SY_IDLE, SY_ASYNC, SY_VERSION, SY_FREQ} stp_sync_t;

  // lane selection and masking of the written value
  function automatic logic [31:0] lane_down(
    input logic [31:0] d,
    input stp_size_t sz,
    input logic be
  );
    logic [31:0] r;
    r = d;
    case (sz)
      SZ_BYTE: r = {24'h00_0000, be ? d[31:24] : d[7:0]};
      SZ_HALF: r = {16'h0000, be ? d[31:16] : d[15:0]};
      default: r = d;
    endcase
    return r;
  endfunction

  // packet kind from the decoded address fields
  function automatic stp_kind_t kind_of(
    input logic data,
    input logic mark,
    input logic trig,
    input logic stamp
  );
    stp_kind_t k;
    k = PK_PLAIN;
    if (data)
    begin
      if (mark)
        k = stamp ? PK_MARKED_STAMPED_WORD : PK_MARKED_WORD;
      else
        k = stamp ? PK_STAMPED_WORD : PK_PLAIN;
    end
    else if (trig)
      k = stamp ? PK_EVENT_STAMPED : PK_TRIGGER;
    else
      k = stamp ? PK_MARKER_STAMPED : PK_FLAG;
    return k;
  endfunction

  logic [31:0] timeNow_r;
  logic [31:0] feature_r;
  logic lostPending_r;
  logic lostUnknown_r;
  logic [STP_MASTER_W-1:0] lostMaster_r;
  logic partOpen_r;
  logic syncPending_r;
  stp_sync_t syncState_r;
  stp_sync_t syncState_nxt;

  logic isInvar;
  logic isData;
  logic isNonData;
  logic isReserved;
  logic stampAsked;
  logic markAsked;
  logic trigAsked;
  logic stampGo;
  stp_size_t pktSize;
  logic [31:0] wrWord;
  logic selLost;
  logic selWrite;
  logic selSync;
  logic fifoInValid;
  logic fifoInReady;
  logic [STP_LEVEL_W-1:0] fifoLevel;
  logic wrTaken;
  logic dropInvar;
  logic lostPushed;
  logic syncPushed;
  stp_packet_t wrPkt;
  stp_packet_t lostPkt;
  stp_packet_t syncPkt;
  stp_packet_t fifoIn;
  stp_kind_t syncKind;
  logic [31:0] syncWord;

  // address decode; bits 2:0 are never looked at
  assign isInvar = wrReq.addr[STP_BIT_INVAR];
  assign isData = !wrReq.addr[STP_BIT_NODATA] && !wrReq.addr[STP_BIT_SUB];
  assign isNonData = wrReq.addr[STP_BIT_NODATA] && wrReq.addr[STP_BIT_SUB];
  assign isReserved = !isData && !isNonData;
  assign stampAsked = !wrReq.addr[STP_BIT_NOSTAMP];
  assign markAsked = !wrReq.addr[STP_BIT_NOMARK];
  assign trigAsked = wrReq.addr[STP_BIT_TRIG];

  // stamp policy: enable gates all, invariant needs queue headroom
  // only requested writes are stamped, none is added unasked
  assign stampGo = stampEnable && stampAsked
    && (!isInvar || (fifoLevel < STP_STAMP_ROOM));

  // payload never wider than one 32 bit word, no compression
  // a 64 bit value arrives as two flagged 32 bit parts
  assign pktSize = (wrReq.size == SZ_DWORD) ? SZ_WORD : wrReq.size;
  assign wrWord = isData ? lane_down(wrReq.data, wrReq.size, bigEndianSys) : 32'h0000_0000;

  // write packet
  assign wrPkt.kind = kind_of(isData, markAsked, trigAsked, stampGo);
  assign wrPkt.master = wrReq.master;
  assign wrPkt.channel = wrReq.addr[STP_PORT_LSB +: STP_PORT_W];
  assign wrPkt.size = isData ? pktSize : SZ_BYTE;
  assign wrPkt.data = wrWord;
  assign wrPkt.stamp = stampGo ? timeNow_r : 32'h0000_0000;

  // lost-trace packet, data bit 0 set when the master is unknown
  assign lostPkt.kind = PK_LOST;
  assign lostPkt.master = lostMaster_r;
  assign lostPkt.channel = '0;
  assign lostPkt.size = SZ_BYTE;
  assign lostPkt.data = {31'h0000_0000, lostUnknown_r};
  assign lostPkt.stamp = 32'h0000_0000;

  // synchronisation packets
  assign syncKind = (syncState_r == SY_ASYNC) ? PK_ASYNC
    : (syncState_r == SY_VERSION) ? PK_VERSION : PK_FREQ;
  assign syncWord = (syncState_r == SY_VERSION) ? STP_VERSION_WORD
    : (syncState_r == SY_FREQ) ? STP_FREQ_HZ : 32'h0000_0000;
  assign syncPkt.kind = syncKind;
  assign syncPkt.master = '0;
  assign syncPkt.channel = '0;
  assign syncPkt.size = SZ_WORD;
  assign syncPkt.data = syncWord;
  assign syncPkt.stamp = 32'h0000_0000;

  // source priority: lost report, then writes, then sync between transactions
  assign selLost = lostPending_r && !partOpen_r;
  assign selWrite = !selLost && wrValid;
  assign selSync = !selLost && !wrValid && !partOpen_r
    && (syncState_r != SY_IDLE);
  assign fifoInValid = selLost || (selWrite && !isReserved) || selSync;
  assign fifoIn = selLost ? lostPkt : (selWrite ? wrPkt : syncPkt);

  // guaranteed writes wait for room; invariant and reserved never stall
  // a waiting lost report holds guaranteed writes back so that it goes first
  assign wrReady = isReserved || isInvar || (fifoInReady && !selLost);
  assign wrTaken = wrValid && wrReady && !isReserved;
  assign dropInvar = wrTaken && isInvar && (selLost || !fifoInReady);
  assign lostPushed = selLost && fifoInReady;
  assign syncPushed = selSync && fifoInReady;

  // packet queue in front of the trace output
  // its fill level also decides whether an invariant write keeps its stamp
  stp_fifo #(
    .WIDTH($bits(stp_packet_t)),
    .DEPTH(STP_FIFO_DEPTH)
  ) u_queue (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(pktValid),
    .outReady(pktReady),
    .outData(pkt),
    .level(fifoLevel)
  );

  // free running stamp counter and feature word
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      timeNow_r <= STP_TIME_RESET;
      feature_r <= STP_FEAT_RESET;
    end
    else
      timeNow_r <= timeNow_r + 32'h0000_0001;
  end

  // lost-trace bookkeeping, a new drop wins over the report leaving
  // drops from more than one master mark the report's master as unknown
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lostPending_r <= 1'b0;
      lostUnknown_r <= 1'b0;
      lostMaster_r <= '0;
    end
    else if (dropInvar)
    begin
      lostPending_r <= 1'b1;
      lostMaster_r <= wrReq.master;
      lostUnknown_r <= (lostPending_r && !lostPushed)
        && (lostUnknown_r || lostMaster_r != wrReq.master);
    end
    else if (lostPushed)
    begin
      lostPending_r <= 1'b0;
      lostUnknown_r <= 1'b0;
    end
  end

  // open multi-part transaction holds off inserted packets
  // a lost or sync packet between two parts would break the pair apart
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      partOpen_r <= 1'b0;
    else if (wrTaken)
      partOpen_r <= wrReq.more;
  end

  // sync request is sticky until the sequence starts; request wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      syncPending_r <= 1'b0;
    else if (syncReq)
      syncPending_r <= 1'b1;
    else if (syncState_r == SY_IDLE)
      syncPending_r <= 1'b0;
  end

  // sync sequence starts on a pending request, then steps on each sync packet queued
  always_comb
  begin
    syncState_nxt = syncState_r;
    case (syncState_r)
      SY_IDLE:
      begin
        if (syncPending_r)
          syncState_nxt = SY_ASYNC;
      end
      SY_ASYNC:
      begin
        if (syncPushed)
          syncState_nxt = SY_VERSION;
      end
      SY_VERSION:
      begin
        if (syncPushed)
          syncState_nxt = stampEnable ? SY_FREQ : SY_IDLE;
      end
      SY_FREQ:
      begin
        if (syncPushed)
          syncState_nxt = SY_IDLE;
      end
      default: syncState_nxt = SY_IDLE;
    endcase
  end

  // sync state register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      syncState_r <= SY_IDLE;
    else
      syncState_r <= syncState_nxt;
  end

  // status outputs
  assign traceLost = lostPending_r;
  assign featureRegisterOne = feature_r;
endmodule // stimulus_trace_packetizer
`default_nettype wire

// ---- testbench/stp_chk.sv ----
// port assertions for the stimulus trace packetizer
`timescale 1ns/1ps
`default_nettype none
module stp_chk
  import stp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire stp_write_t wrReq,
  input wire logic stampEnable,
  input wire logic pktValid,
  input wire logic pktReady,
  input wire stp_packet_t pkt,
  input wire logic traceLost,
  input wire logic [31:0] featureRegisterOne
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // decode of a guaranteed write taken into an empty queue
  wire [1:0] a65 = wrReq.addr[6:5];
  wire nd = a65 == 2'b11;
  wire gData = !wrReq.addr[7] && (a65 == 2'b00 || nd);
  wire gTake = wrValid && wrReady && gData && !pktValid;
  wire [3:0] kExp = {1'b0, nd, nd ? wrReq.addr[4] : !wrReq.addr[4],
    !wrReq.addr[3] && stampEnable};
  sequence s_async_out;
    pktValid && pktReady && pkt.kind == PK_ASYNC;
  endsequence
  sequence s_version_next;
    ##[1:20] pktValid && pkt.kind == PK_VERSION;
  endsequence
  property p_sync;
    s_async_out |-> s_version_next;
  endproperty
  a_sync: assert property (p_sync) else $error("no version after async");
  property p_kind;
    gTake |=> pkt.kind == $past(kExp);
  endproperty
  a_kind: assert property (p_kind) else $error("wrong packet kind");
  property p_chan;
    gTake |=> pktValid && pkt.channel == $past(wrReq.addr[11:8]);
  endproperty
  a_chan: assert property (p_chan) else $error("wrong channel");
  property p_nodata;
    gTake && nd |=> pkt.data == 32'h0000_0000;
  endproperty
  a_nodata: assert property (p_nodata) else $error("flag carries data");
  property p_size;
    pktValid |-> pkt.size != SZ_DWORD;
  endproperty
  a_size: assert property (p_size) else $error("payload too wide");
  property p_feat;
    featureRegisterOne == 32'h0000_0001;
  endproperty
  a_feat: assert property (p_feat) else $error("feature word wrong");
  property p_lost;
    traceLost && wrValid && gData |-> !wrReady;
  endproperty
  a_lost: assert property (p_lost) else $error("trace resumed early");
  property p_hold;
    pktValid && !pktReady |=> pktValid && $stable(pkt);
  endproperty
  a_hold: assert property (p_hold) else $error("packet lost while stalled");
  property p_inv;
    wrValid && wrReq.addr[7] |-> wrReady;
  endproperty
  a_inv: assert property (p_inv) else $error("invariant write stalled");
endmodule // stp_chk
bind stimulus_trace_packetizer stp_chk u_chk (.clock, .rst_n, .wrValid, .wrReady,
  .wrReq, .stampEnable, .pktValid, .pktReady, .pkt, .traceLost, .featureRegisterOne);
`default_nettype wire

// ---- testbench/stp_master.sv ----
// write master model standing for the interconnect
`timescale 1ns/1ps
`default_nettype none
module stp_master
  import stp_pkg::*;
(
  input wire logic clock,
  input wire logic wrReady,
  output logic wrValid,
  output stp_write_t wrReq
);
  initial
  begin
    wrValid = 1'b0;
    wrReq = '0;
  end
  // one write held until taken or lim cycles pass; ok stays low if never taken
  task automatic send(input logic [11:0] a, input stp_size_t sz, input logic [31:0] d,
    input logic mo, input logic [7:0] m, input int lim, output logic ok);
    int i;
    ok = 1'b0;
    @(negedge clock);
    wrValid = 1'b1;
    wrReq = '{addr: a, size: sz, data: d, master: m, more: mo};
    for (i = 0; i < lim && !ok; i++)
    begin
      @(posedge clock);
      ok = wrReady;
    end
    @(negedge clock);
    wrValid = 1'b0;
    wrReq.data = ~d; // released data does not keep its value
  endtask
endmodule // stp_master
`default_nettype wire

// ---- testbench/tb_stimulus_trace_packetizer.sv ----
// bench for the stimulus trace packetizer
`timescale 1ns/1ps
`default_nettype none
module tb_stimulus_trace_packetizer
  import stp_pkg::*;
();
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bigEndianSys = 1'b0;
  logic stampEnable = 1'b0;
  logic syncReq = 1'b0;
  logic pktReady = 1'b0;
  logic wrValid, wrReady, pktValid, traceLost, ok;
  logic [31:0] featureRegisterOne;
  stp_write_t wrReq;
  stp_packet_t pkt, p;
  int err_count = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  stp_master u_mst (.clock, .wrReady, .wrValid, .wrReq);
  stimulus_trace_packetizer uut (.clock, .rst_n, .wrValid, .wrReady, .wrReq,
    .bigEndianSys, .stampEnable, .syncReq, .pktValid, .pktReady, .pkt, .traceLost,
    .featureRegisterOne);
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // take one packet, bounded wait
  task automatic rd(output stp_packet_t q);
    int i;
    @(negedge clock);
    pktReady = 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clock);
      if (pktValid === 1'b1)
        break;
    end
    q = pkt;
    @(negedge clock);
    pktReady = 1'b0;
    if (i == 50)
    begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic w(input logic [11:0] a, input stp_size_t s, input logic [31:0] d,
    input logic m);
    u_mst.send(a, s, d, m, 8'h05, 20, ok);
    chk("taken", 32'h0000_0001, 32'(ok));
    if (ok !== 1'b1)
      print_verdict();
  endtask
  task automatic ex(input stp_kind_t k, input logic [3:0] c, input logic [31:0] d);
    rd(p);
    chk("kind", 32'(k), 32'(p.kind));
    chk("channel", 32'(c), 32'(p.channel));
    chk("data", d, p.data);
  endtask
  task automatic t_lanes();
    w(12'h118, SZ_WORD, 32'h1122_3344, 1'b0);
    ex(PK_PLAIN, 4'h1, 32'h1122_3344);
    chk("low byte", 32'h0000_0044, {24'h00_0000, p.data[7:0]});
    bigEndianSys = 1'b1;
    w(12'h218, SZ_BYTE, 32'hab00_0000, 1'b0);
    rd(p);
    chk("swizzled", 32'h0000_00ab, {24'h00_0000, p.data[7:0]});
    bigEndianSys = 1'b0;
  endtask
  task automatic t_pair();
    w(12'h200, SZ_WORD, 32'ha5a5_0001, 1'b1);
    w(12'h204, SZ_WORD, 32'h5a5a_0002, 1'b0);
    ex(PK_MARKED_WORD, 4'h2, 32'ha5a5_0001);
    ex(PK_MARKED_WORD, 4'h2, 32'h5a5a_0002);
    chk("size", 32'(SZ_WORD), 32'(p.size));
  endtask
  task automatic t_kinds();
    int i;
    logic [3:0] k;
    for (i = 0; i < 16; i++)
    begin
      stampEnable = i[3];
      k = {1'b0, i[2], i[2] ? i[1] : !i[1], !i[0] && i[3]};
      w({4'h3, 1'b0, i[2], i[2], i[1], i[0], 3'b000}, SZ_WORD, 32'h0c00 + 32'(i), 1'b0);
      ex(stp_kind_t'(k), 4'h3, i[2] ? 32'h0000_0000 : 32'h0c00 + 32'(i));
      if (!k[0])
        chk("no stamp", 32'h0000_0000, p.stamp);
    end
    stampEnable = 1'b0;
  endtask
  // invariant stamped writes keep their stamp only while the queue has headroom
  task automatic t_invstamp();
    stampEnable = 1'b1;
    w(12'h390, SZ_WORD, 32'h0000_0a01, 1'b0);
    w(12'h390, SZ_WORD, 32'h0000_0a02, 1'b0);
    w(12'h390, SZ_WORD, 32'h0000_0a03, 1'b0);
    stampEnable = 1'b0;
    ex(PK_STAMPED_WORD, 4'h3, 32'h0000_0a01);
    ex(PK_STAMPED_WORD, 4'h3, 32'h0000_0a02);
    ex(PK_PLAIN, 4'h3, 32'h0000_0a03);
    chk("dropped stamp", 32'h0000_0000, p.stamp);
  endtask
  task automatic fill();
    int i;
    for (i = 0; i < 4; i++)
      w(12'h318, SZ_WORD, 32'(i), 1'b0);
  endtask
  task automatic t_stall(input logic lost);
    int i;
    fill();
    if (lost)
    begin
      u_mst.send(12'h398, SZ_WORD, 32'hdead_0000, 1'b0, 8'h09, 3, ok);
      chk("lost flag", 32'h0000_0001, 32'(traceLost));
    end
    fork
      u_mst.send(12'h318, SZ_WORD, 32'h0000_0004, 1'b0, 8'h05, 60, ok);
      begin
        repeat (5) @(negedge clock);
        chk("ready while full", 32'h0000_0000, 32'(wrReady));
        for (i = 0; i < 4; i++)
          ex(PK_PLAIN, 4'h3, 32'(i));
        if (lost)
          ex(PK_LOST, 4'h0, 32'h0000_0000);
        chk("lost master", lost ? 32'h0000_0009 : 32'h0000_0005, 32'(p.master));
        ex(PK_PLAIN, 4'h3, 32'h0000_0004);
      end
    join
    chk("stalled taken", 32'h0000_0001, 32'(ok));
  endtask
  task automatic t_sync();
    int j;
    for (j = 0; j < 2; j++)
    begin
      stampEnable = !j[0];
      syncReq = 1'b1;
      @(negedge clock);
      syncReq = 1'b0;
      ex(PK_ASYNC, 4'h0, 32'h0000_0000);
      ex(PK_VERSION, 4'h0, STP_VERSION_WORD);
      if (j == 0)
        ex(PK_FREQ, 4'h0, STP_FREQ_HZ);
      repeat (4) @(negedge clock);
      chk("sync ended", 32'h0000_0000, 32'(pktValid));
    end
  endtask
  // reset, then the scenarios
  initial
  begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    chk("feature", 32'h0000_0001, featureRegisterOne);
    t_lanes();
    t_pair();
    t_kinds();
    t_invstamp();
    t_stall(1'b0);
    t_stall(1'b1);
    t_sync();
    print_verdict();
  end
endmodule // tb_stimulus_trace_packetizer
`default_nettype wire
